/* hw/aea_acc.sv */
// Unsigned add-only energy accumulator with half-full and carry events
`timescale 1ns/1ns
module aea_acc #(
   parameter int W  = 42,
   parameter int VW = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Owner side
   aea_acc_if.acc   a
);
   logic [W-1:0] base;
   logic [W:0]   sum;

   // Clear happens before the add, so a sample in a clear cycle is kept
   always_comb begin
      base = a.value;
      if (a.clr_all) begin
         base = '0;
      end else if (a.clr_upper) begin
         base = {{VW{1'b0}}, a.value[W-VW-1:0]};
      end
      sum = {1'b0, base} + (a.add_en ? {1'b0, a.add_val} : {(W+1){1'b0}});
   end

   // Value grows except on a clear; a carry out of the top wraps it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a.value <= '0;
      end else begin
         a.value <= sum[W-1:0];
      end
   end

   // One-cycle events: top bit first set, carry out of the top bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a.carry <= 1'b0;
         a.half  <= 1'b0;
      end else begin
         a.carry <= a.add_en & sum[W];
         a.half  <= a.add_en & ~base[W-1] & sum[W-1];
      end
   end
endmodule

/* hw/aea_acc_if.sv */
// Link between the accumulator owner and one energy accumulator
`timescale 1ns/1ns
interface aea_acc_if #(parameter int W = 42);
   logic         add_en;
   logic [W-1:0] add_val;
   logic         clr_upper;
   logic         clr_all;
   logic [W-1:0] value;
   logic         carry;
   logic         half;
   modport owner (output add_en, add_val, clr_upper, clr_all, input value, carry, half);
   modport acc   (input add_en, add_val, clr_upper, clr_all, output value, carry, half);
endinterface

/* hw/aea_pkg.sv */
// Shared types of the apparent energy block
package aea_pkg;
   typedef logic [31:0] aea_word_t;
   typedef logic [3:0]  aea_flags_t;
   typedef enum logic [1:0] {
      AEA_LC_WAIT = 2'b00,
      AEA_LC_RUN  = 2'b01
   } aea_lc_state_t;
endpackage

/* hw/aea_regs.svh */
// Register map, field positions, reset values and timing for the apparent energy block
`ifndef AEA_REGS_SVH
`define AEA_REGS_SVH

// Register byte offsets
`define AEA_OFS_CTRL       8'h00
`define AEA_OFS_GAIN1      8'h04
`define AEA_OFS_GAIN2      8'h08
`define AEA_OFS_DIV        8'h0C
`define AEA_OFS_COUNT      8'h10
`define AEA_OFS_VIEW       8'h14
`define AEA_OFS_CLR_VIEW   8'h18
`define AEA_OFS_LINE_VIEW  8'h1C
`define AEA_OFS_FLAGS      8'h20
`define AEA_OFS_MASK       8'h24

// Control register fields
`define AEA_CTRL_WIRING    0
`define AEA_CTRL_CE_DIS    1
`define AEA_CTRL_NL_LO     2
`define AEA_CTRL_NL_HI     3

// Flag and mask bit positions
`define AEA_FLG_NOLOAD     0
`define AEA_FLG_HALF       1
`define AEA_FLG_OVF        2
`define AEA_FLG_CEND       3

// Reset values
`define AEA_RST_CTRL       4'h0
`define AEA_RST_GAIN       12'h000
`define AEA_RST_DIV        8'h00
`define AEA_RST_COUNT      16'h0000
`define AEA_RST_MASK       4'hF

// Widths
`define AEA_ACC_W          42
`define AEA_VIEW_W         24
`define AEA_GAIN_W         12
`define AEA_GAIN_FRAC      12

// No-load thresholds: 0.03, 0.015 and 0.0075 percent of 2^21 full scale
`define AEA_NL_TH_01       629
`define AEA_NL_TH_10       315
`define AEA_NL_TH_11       157

// Timing: sample period 230.4 us
`define AEA_CLK_PERIOD_NS     50
`define AEA_SAMPLE_PERIOD_NS  230400

`endif

/* hw/aea_top.sv */
// Apparent power trim, no-load gate, energy accumulation and Wishbone registers
`timescale 1ns/1ns
`include "aea_regs.svh"
// How it works
// R1: Two-wire: V1 times I1; three-wire: half of both channel products.
// R2: Each channel scaled by one plus signed 12-bit gain over 4096.
// R3: No-load code 00 off; 01, 10, 11 select 0.03, 0.015, 0.0075 percent.
// R4: Below an enabled threshold a sample is not accumulated.
// R5: Below the threshold the no-load flag sets.
// R6: Unmasked no-load flag interrupts until software clears the flag.
// R7: The same no-load gate also blanks the pulse converter power.
// R8: 42-bit accumulator, upper 24 bits readable.
// R9: One sample added every 230.4 us.
// R10: Each sample divided by the 8-bit divider first.
// R11: Divider zero behaves as one.
// R12: Plain view read returns upper 24 bits, accumulator untouched.
// R13: Clear view read returns upper 24 bits, then clears them.
// R14: Accumulator is only ever added to.
// R15: Half-full and overflow flags, each interrupting when unmasked.
// R16: Half point is the unsigned 24-bit half, the top bit.
// R17: Half-full when bit 41 first sets; overflow on carry from bit 41.
// R18: Line windows aligned to zero crossings, spanning programmed half cycles.
// R19: Half-cycle count is 16 bits, up to 65535.
// R20: Window end sets cycle-end flag; unmasked it interrupts until cleared.
// R21: Next window starts at once; line view overwritten by next result.
// R22: Count write clears line view and restarts at next zero crossing.
// R23: Cycle-end disable stops the flag and the clears on count writes.
module aea_top
   import aea_pkg::*;
#(
   parameter int RMS_W      = 16,
   parameter int P_W        = 22,
   parameter int SAMPLE_CYC = `AEA_SAMPLE_PERIOD_NS / `AEA_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Wishbone classic slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  aea_pkg::aea_word_t    wb_dat_i,
   output aea_pkg::aea_word_t    wb_dat_o,
   output logic                  wb_ack_o,
   // RMS inputs and zero crossing pulse
   input  wire logic [RMS_W-1:0] v1_rms,
   input  wire logic [RMS_W-1:0] i1_rms,
   input  wire logic [RMS_W-1:0] v2_rms,
   input  wire logic [RMS_W-1:0] i2_rms,
   input  wire logic             zero_cross,
   // Pulse converter feed and interrupt
   output logic [P_W-1:0]        energy_pulse_power,
   output logic                  energy_pulse_valid,
   output logic                  irq
);
   import aea_pkg::*;

   localparam int ACC_W = `AEA_ACC_W;
   localparam int VW    = `AEA_VIEW_W;
   localparam int SC_W  = $clog2(SAMPLE_CYC);

   // Registers
   logic [3:0]            ctrl;
   logic [11:0]           apparent_gain_ch1;
   logic [11:0]           apparent_gain_ch2;
   logic [7:0]            apparent_energy_divider;
   logic [15:0]           half_cycle_count;
   logic [VW-1:0]         apparent_energy_line_view;
   aea_flags_t            flags;
   aea_flags_t            mask;
   aea_flags_t            next_flags;
   aea_flags_t            flag_set;
   aea_flags_t            flag_clr;

   // Datapath
   logic [SC_W-1:0]       smp_cnt;
   logic                  tick;
   logic [2*RMS_W-1:0]    prod1;
   logic [2*RMS_W-1:0]    prod2;
   logic [P_W-1:0]        trim1;
   logic [P_W-1:0]        trim2;
   logic [P_W:0]          sum2;
   logic [P_W-1:0]        ap;
   logic [P_W-1:0]        threshold;
   logic                  nl_enable;
   logic                  below;
   logic [7:0]            div_eff;
   logic [P_W-1:0]        scaled;

   // Line cycle
   aea_lc_state_t         lc_state;
   logic [15:0]           hcnt;
   logic                  lc_end;
   logic                  cnt_wr;
   logic                  ce_dis;

   // Bus
   logic                  req;
   logic                  wr_go;
   logic                  rd_go;
   aea_word_t             cur_word;
   aea_word_t             wr_word;

   aea_acc_if #(.W(ACC_W)) main_if ();
   aea_acc_if #(.W(ACC_W)) line_if ();

   // Signed gain trim, saturated to the unsigned power range
   function automatic logic [P_W-1:0] trim(input logic [P_W-1:0] p,
                                           input logic [11:0] g);
      logic signed [P_W+13:0] prod;
      logic signed [P_W+1:0]  res;
      prod = $signed({1'b0, p}) * $signed(g);
      res  = $signed({2'b00, p}) + $signed(prod[P_W+13:`AEA_GAIN_FRAC]);
      if (res[P_W+1]) begin
         return '0;
      end else if (res[P_W]) begin
         return '1;
      end
      return res[P_W-1:0];
   endfunction

   // Byte-lane merge of a write into the addressed register
   function automatic aea_word_t merge(input aea_word_t old, input aea_word_t nw,
                                       input logic [3:0] sel);
      aea_word_t r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // R9: sample rate divider
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         smp_cnt <= '0;
      end else if (tick) begin
         smp_cnt <= '0;
      end else begin
         smp_cnt <= smp_cnt + 1'b1;
      end
   end
   assign tick = (smp_cnt == SC_W'(SAMPLE_CYC - 1));

   // R1: products of RMS pairs, top bits kept as power
   assign prod1 = v1_rms * i1_rms;
   assign prod2 = v2_rms * i2_rms;
   // R2: channel gain trims
   assign trim1 = trim(prod1[2*RMS_W-1 -: P_W], apparent_gain_ch1);
   assign trim2 = trim(prod2[2*RMS_W-1 -: P_W], apparent_gain_ch2);
   assign sum2  = {1'b0, trim1} + {1'b0, trim2};
   // R1: wiring select picks one channel or the mean of both
   assign ap    = ctrl[`AEA_CTRL_WIRING] ? sum2[P_W:1] : trim1;

   // R3: threshold select, code zero turns detection off
   always_comb begin
      case ({ctrl[`AEA_CTRL_NL_HI], ctrl[`AEA_CTRL_NL_LO]})
         2'b01:   threshold = P_W'(`AEA_NL_TH_01);
         2'b10:   threshold = P_W'(`AEA_NL_TH_10);
         2'b11:   threshold = P_W'(`AEA_NL_TH_11);
         default: threshold = '0;
      endcase
   end
   assign nl_enable = ctrl[`AEA_CTRL_NL_HI] | ctrl[`AEA_CTRL_NL_LO];
   assign below     = nl_enable & (ap < threshold);

   // R11: a zero divider acts as one
   assign div_eff = (apparent_energy_divider == 8'h00) ? 8'h01 : apparent_energy_divider;
   // R10: scale before accumulation
   assign scaled  = ap / {{(P_W-8){1'b0}}, div_eff};

   // R4: no-load samples are not added
   assign main_if.add_en    = tick & ~below;
   // R14: unsigned addend only, never subtracted
   assign main_if.add_val   = {{(ACC_W-P_W){1'b0}}, scaled};
   // R13: clear-on-read wipes the upper bits
   assign main_if.clr_upper = rd_go & (wb_adr_i == `AEA_OFS_CLR_VIEW);
   assign main_if.clr_all   = 1'b0;

   // R8: main 42-bit accumulator
   aea_acc #(.W(ACC_W), .VW(VW)) u_main (
      .clk   (clk),
      .rst_n (rst_n),
      .a     (main_if)
   );

   // R18: line accumulator runs only inside an aligned window
   assign line_if.add_en    = tick & ~below & (lc_state == AEA_LC_RUN);
   assign line_if.add_val   = main_if.add_val;
   assign line_if.clr_upper = 1'b0;
   // R22: count write clears the inner sum unless disabled
   assign line_if.clr_all   = lc_end | (cnt_wr & ~ce_dis);

   aea_acc #(.W(ACC_W), .VW(VW)) u_line (
      .clk   (clk),
      .rst_n (rst_n),
      .a     (line_if)
   );

   // R7: pulse feed uses the same no-load gate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         energy_pulse_power <= '0;
         energy_pulse_valid <= 1'b0;
      end else begin
         energy_pulse_valid <= tick;
         if (tick) begin
            energy_pulse_power <= below ? '0 : scaled;
         end
      end
   end

   // R18: window ends on the zero crossing that completes the count
   assign ce_dis = ctrl[`AEA_CTRL_CE_DIS];
   assign lc_end = zero_cross & (lc_state == AEA_LC_RUN) & (half_cycle_count != 16'h0000)
                   & (hcnt == half_cycle_count - 16'h0001);

   // R21: a new window starts in the cycle the old one ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lc_state <= AEA_LC_WAIT;
         hcnt     <= 16'h0000;
      end else if (cnt_wr) begin
         // R22: restart from the next zero crossing
         lc_state <= AEA_LC_WAIT;
         hcnt     <= 16'h0000;
      end else begin
         case (lc_state)
            AEA_LC_WAIT: begin
               if (zero_cross) begin
                  lc_state <= AEA_LC_RUN;
               end
            end
            AEA_LC_RUN: begin
               if (lc_end) begin
                  hcnt <= 16'h0000;
               end else if (zero_cross) begin
                  hcnt <= hcnt + 16'h0001;
               end
            end
            default: lc_state <= AEA_LC_WAIT;
         endcase
      end
   end

   // R21: each result overwrites the line view, read or not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         apparent_energy_line_view <= '0;
      end else if (cnt_wr & ~ce_dis) begin
         // R22: count write clears the result
         apparent_energy_line_view <= '0;
      end else if (lc_end) begin
         apparent_energy_line_view <= line_if.value[ACC_W-1 -: VW];
      end
   end

   // Bus decode; a request is served once, in its first cycle
   assign req    = wb_cyc_i & wb_stb_i;
   assign wr_go  = req & wb_we_i & ~wb_ack_o;
   assign rd_go  = req & ~wb_we_i & ~wb_ack_o;
   assign cnt_wr = wr_go & (wb_adr_i == `AEA_OFS_COUNT);

   // Current contents of the addressed word; unmapped reads as zero
   always_comb begin
      case (wb_adr_i)
         `AEA_OFS_CTRL:      cur_word = {28'h0000000, ctrl};
         `AEA_OFS_GAIN1:     cur_word = {20'h00000, apparent_gain_ch1};
         `AEA_OFS_GAIN2:     cur_word = {20'h00000, apparent_gain_ch2};
         `AEA_OFS_DIV:       cur_word = {24'h000000, apparent_energy_divider};
         `AEA_OFS_COUNT:     cur_word = {16'h0000, half_cycle_count};
         // R12: plain view has no side effect
         `AEA_OFS_VIEW:      cur_word = {8'h00, main_if.value[ACC_W-1 -: VW]};
         `AEA_OFS_CLR_VIEW:  cur_word = {8'h00, main_if.value[ACC_W-1 -: VW]};
         `AEA_OFS_LINE_VIEW: cur_word = {8'h00, apparent_energy_line_view};
         `AEA_OFS_FLAGS:     cur_word = {28'h0000000, flags};
         `AEA_OFS_MASK:      cur_word = {28'h0000000, mask};
         default:            cur_word = 32'h00000000;
      endcase
   end
   assign wr_word = merge(cur_word, wb_dat_i, wb_sel_i);

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (rd_go) begin
            wb_dat_o <= cur_word;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl                    <= `AEA_RST_CTRL;
         apparent_gain_ch1       <= `AEA_RST_GAIN;
         apparent_gain_ch2       <= `AEA_RST_GAIN;
         apparent_energy_divider <= `AEA_RST_DIV;
         half_cycle_count        <= `AEA_RST_COUNT;
         mask                    <= `AEA_RST_MASK;
      end else if (wr_go) begin
         case (wb_adr_i)
            `AEA_OFS_CTRL:  ctrl                    <= wr_word[3:0];
            `AEA_OFS_GAIN1: apparent_gain_ch1       <= wr_word[11:0];
            `AEA_OFS_GAIN2: apparent_gain_ch2       <= wr_word[11:0];
            `AEA_OFS_DIV:   apparent_energy_divider <= wr_word[7:0];
            // R19: 16-bit half-cycle count
            `AEA_OFS_COUNT: half_cycle_count        <= wr_word[15:0];
            `AEA_OFS_MASK:  mask                    <= wr_word[3:0];
            default:        ;
         endcase
      end
   end

   // Sticky flags, write one to clear; a set in the clear cycle wins
   always_comb begin
      flag_set = 4'h0;
      // R5: no-load request
      flag_set[`AEA_FLG_NOLOAD] = tick & below;
      // R16: half point is the top bit of the unsigned view
      // R17: half-full on top bit rising, overflow on carry
      flag_set[`AEA_FLG_HALF]   = main_if.half;
      flag_set[`AEA_FLG_OVF]    = main_if.carry;
      // R23: disable suppresses the cycle-end flag
      flag_set[`AEA_FLG_CEND]   = lc_end & ~ce_dis;
      flag_clr = (wr_go & (wb_adr_i == `AEA_OFS_FLAGS)) ? (wb_dat_i[3:0] & {4{wb_sel_i[0]}})
                                                         : 4'h0;
      next_flags = (flags & ~flag_clr) | flag_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= 4'h0;
      end else begin
         flags <= next_flags;
      end
   end

   // R6 R20: flag interrupt holds until software clears it
   // R15: unmasked flags drive the interrupt until cleared
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & ~mask);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_noload_skip; // R4
      tick && below |-> !main_if.add_en && !line_if.add_en;
   endproperty
   a_noload_skip: assert property (p_noload_skip) else $error("no-load sample added");

   property p_noload_flag; // R5
      tick && below |=> flags[`AEA_FLG_NOLOAD];
   endproperty
   a_noload_flag: assert property (p_noload_flag) else $error("no-load flag not set");

   property p_noload_irq; // R6
      flags[`AEA_FLG_NOLOAD] && !mask[`AEA_FLG_NOLOAD] |=> irq;
   endproperty
   a_noload_irq: assert property (p_noload_irq) else $error("no-load interrupt missing");

   property p_tick_gap; // R9
      tick |=> !tick [*2];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("sample ticks too close");

   property p_div_zero; // R11
      apparent_energy_divider == 8'h00 && main_if.add_en |-> main_if.add_val[P_W-1:0] == ap;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero divider not treated as one");

   property p_clear_view; // R13
      main_if.clr_upper && !tick |=> main_if.value[ACC_W-1 -: VW] == '0;
   endproperty
   a_clear_view: assert property (p_clear_view) else $error("clear view did not clear");

   property p_grow; // R14
      !main_if.clr_upper |=> main_if.value >= $past(main_if.value) || main_if.carry;
   endproperty
   a_grow: assert property (p_grow) else $error("accumulator decreased");

   property p_ovf_flag; // R17
      main_if.carry |-> ##0 next_flags[`AEA_FLG_OVF] ##1 flags[`AEA_FLG_OVF];
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

   property p_cycle_end; // R20
      lc_end && !ce_dis |=> flags[`AEA_FLG_CEND] && hcnt == 16'h0000 && lc_state == AEA_LC_RUN;
   endproperty
   a_cycle_end: assert property (p_cycle_end) else $error("cycle end not handled");

   property p_count_write; // R22
      cnt_wr && !ce_dis |=> apparent_energy_line_view == '0 && lc_state == AEA_LC_WAIT;
   endproperty
   a_count_write: assert property (p_count_write) else $error("count write did not restart");
endmodule

/* verif/aea_far_model.sv */
// Far-side model: RMS level sources, zero crossing pulser and pulse-converter monitor
`timescale 1ns/1ns
module aea_far_model #(
   parameter int RMS_W = 16,
   parameter int P_W   = 22
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // RMS levels and zero crossing
   output logic [RMS_W-1:0]      v1_rms,
   output logic [RMS_W-1:0]      i1_rms,
   output logic [RMS_W-1:0]      v2_rms,
   output logic [RMS_W-1:0]      i2_rms,
   output logic                  zero_cross,
   // Pulse converter feed
   input  wire logic [P_W-1:0]   energy_pulse_power,
   input  wire logic             energy_pulse_valid
);
   logic [P_W-1:0] last_pow;
   int             n_valid;
   int             gap;
   int             since;

   // Quiet levels until the bench asks for power
   initial begin
      v1_rms = '0;
      i1_rms = '0;
      v2_rms = '0;
      i2_rms = '0;
      zero_cross = 1'b0;
   end

   // Levels change just after an edge, never in the middle of a cycle
   task automatic set_lv(input logic [RMS_W-1:0] v1, input logic [RMS_W-1:0] i1,
                         input logic [RMS_W-1:0] v2, input logic [RMS_W-1:0] i2);
      v1_rms <= v1;
      i1_rms <= i1;
      v2_rms <= v2;
      i2_rms <= i2;
   endtask

   task automatic pulse_zc();
      zero_cross <= 1'b1;
      @(posedge clk);
      zero_cross <= 1'b0;
   endtask

   // Converter side: keep the last power word and the spacing of samples
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_pow <= '0;
         n_valid  <= 0;
         since    <= 0;
      end else if (energy_pulse_valid) begin
         last_pow <= energy_pulse_power;
         n_valid  <= n_valid + 1;
         gap      <= since;
         since    <= 1;
      end else begin
         since <= since + 1;
      end
   end
endmodule

/* verif/aea_top_tb.sv */
// Self-checking bench for the apparent energy block
`timescale 1ns/1ns
`include "aea_regs.svh"
module aea_top_tb;
   import aea_pkg::*;
   localparam int SCYC = 8;
   typedef struct packed {
      logic [3:0]  ctrl;
      logic [11:0] gain;
      logic [7:0]  div;
      logic [15:0] v;
      logic [15:0] i;
      logic [21:0] pw;
      logic        nl;
   } aea_row_t;
   // Bus and pin signals
   logic            clk, rst_n, wb_cyc, wb_stb, wb_we, zc, irq, pv, ack;
   logic [7:0]      wb_adr;
   logic [15:0]     v1, i1, v2, i2;
   logic [21:0]     pp;
   aea_word_t       wb_dat, dat_o, q;
   int              err_total, cmp_count;
   // Control, gain, divider and levels beside the power and no-load flag they give
   aea_row_t        rows [9] = '{
      '{4'h0, 12'h000, 8'h00, 16'h8000, 16'h2000, 22'h040000, 1'b0},
      '{4'h0, 12'h7FF, 8'h01, 16'h8000, 16'h2000, 22'h05FFC0, 1'b0},
      '{4'h0, 12'h800, 8'h01, 16'h8000, 16'h2000, 22'h020000, 1'b0},
      '{4'h0, 12'h000, 8'h04, 16'h8000, 16'h2000, 22'h010000, 1'b0},
      '{4'h1, 12'h000, 8'h01, 16'h8000, 16'h2000, 22'h020000, 1'b0},
      '{4'h4, 12'h000, 8'h01, 16'h0190, 16'h0400, 22'h000000, 1'b1},
      '{4'h8, 12'h000, 8'h01, 16'h0190, 16'h0400, 22'h000190, 1'b0},
      '{4'hC, 12'h000, 8'h01, 16'h0190, 16'h0400, 22'h000190, 1'b0},
      '{4'h0, 12'h000, 8'h01, 16'h0190, 16'h0400, 22'h000190, 1'b0}
   };

   aea_top #(.SAMPLE_CYC(SCYC)) aea_top_inst (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .v1_rms(v1), .i1_rms(i1), .v2_rms(v2), .i2_rms(i2), .zero_cross(zc),
      .energy_pulse_power(pp), .energy_pulse_valid(pv), .irq(irq));
   aea_far_model aea_far_model_inst (
      .clk(clk), .rst_n(rst_n), .v1_rms(v1), .i1_rms(i1), .v2_rms(v2), .i2_rms(i2),
      .zero_cross(zc), .energy_pulse_power(pp), .energy_pulse_valid(pv));

   // Clock at 20 MHz
   always #25 clk = ~clk;

   task automatic chk(input aea_word_t seen, input aea_word_t exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Classic single cycle; the request stands until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input aea_word_t d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      // A bus that never answers counts as a mismatch
      if (ack !== 1'b1) begin
         err_total++;
      end
      q = dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] adr, input aea_word_t d);
      wb(1'b1, adr, d);
   endtask

   task automatic rd(input logic [7:0] adr, input aea_word_t exp);
      wb(1'b0, adr, 32'h0);
      chk(q, exp);
   endtask

   // Waits for n sample pulses; returns two edges after the last sample was taken
   task automatic waitv(input int n);
      int t, k;
      t = aea_far_model_inst.n_valid + n;
      k = 0;
      while (aea_far_model_inst.n_valid < t && k < 200) begin
         @(posedge clk);
         k++;
      end
      // Samples that stop coming count as a mismatch
      if (aea_far_model_inst.n_valid < t) begin
         err_total++;
      end
   endtask

   // Crossing placed between samples so a window holds a whole number of them
   task automatic half(input int n);
      waitv(n);
      aea_far_model_inst.pulse_zc();
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Whole run is under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_dat = 32'h0;
      err_total = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Ordinary trim, divider, wiring and no-load cases
      foreach (rows[r]) begin
         wr(`AEA_OFS_CTRL, {28'h0, rows[r].ctrl});
         wr(`AEA_OFS_GAIN1, {20'h0, rows[r].gain});
         wr(`AEA_OFS_DIV, {24'h0, rows[r].div});
         aea_far_model_inst.set_lv(rows[r].v, rows[r].i, 16'h0, 16'h0);
         waitv(2);
         wr(`AEA_OFS_FLAGS, 32'hF);
         waitv(2);
         chk({10'h0, aea_far_model_inst.last_pow}, {10'h0, rows[r].pw});
         rd(`AEA_OFS_FLAGS, {31'h0, rows[r].nl});
      end
      chk(aea_word_t'(aea_far_model_inst.gap), SCYC);
      // Exactly five samples of one view step each
      aea_far_model_inst.set_lv(16'h0, 16'h0, 16'h0, 16'h0);
      waitv(2);
      wb(1'b0, `AEA_OFS_CLR_VIEW, 32'h0);
      rd(`AEA_OFS_VIEW, 32'h0);
      waitv(1);
      aea_far_model_inst.set_lv(16'h8000, 16'h2000, 16'h0, 16'h0);
      waitv(5);
      aea_far_model_inst.set_lv(16'h0, 16'h0, 16'h0, 16'h0);
      rd(`AEA_OFS_VIEW, 32'h5);
      rd(`AEA_OFS_VIEW, 32'h5);
      rd(`AEA_OFS_CLR_VIEW, 32'h5);
      rd(`AEA_OFS_VIEW, 32'h0);
      // No-load interrupt holds until its flag is cleared
      wr(`AEA_OFS_CTRL, 32'h4);
      aea_far_model_inst.set_lv(16'h0190, 16'h0400, 16'h0, 16'h0);
      waitv(2);
      wr(`AEA_OFS_MASK, 32'hE);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      waitv(1);
      aea_far_model_inst.set_lv(16'h8000, 16'h2000, 16'h0, 16'h0);
      waitv(2);
      chk({31'h0, irq}, 32'h1);
      wr(`AEA_OFS_FLAGS, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Two windows of two half cycles; the second at double power overwrites the first
      wr(`AEA_OFS_CTRL, 32'h0);
      wr(`AEA_OFS_FLAGS, 32'hF);
      wr(`AEA_OFS_MASK, 32'h7);
      wr(`AEA_OFS_COUNT, 32'h2);
      half(1);
      half(2);
      half(2);
      aea_far_model_inst.set_lv(16'h8000, 16'h4000, 16'h0, 16'h0);
      half(2);
      half(2);
      rd(`AEA_OFS_LINE_VIEW, 32'h8);
      rd(`AEA_OFS_FLAGS, 32'h8);
      chk({31'h0, irq}, 32'h1);
      wr(`AEA_OFS_COUNT, 32'h2);
      rd(`AEA_OFS_LINE_VIEW, 32'h0);
      // Cycle-end disabled: no flag, no clear on a count write
      wr(`AEA_OFS_CTRL, 32'h2);
      wr(`AEA_OFS_FLAGS, 32'hF);
      half(1);
      half(2);
      half(2);
      rd(`AEA_OFS_LINE_VIEW, 32'h8);
      rd(`AEA_OFS_FLAGS, 32'h0);
      wr(`AEA_OFS_COUNT, 32'hFFFF);
      rd(`AEA_OFS_LINE_VIEW, 32'h8);
      rd(`AEA_OFS_COUNT, 32'hFFFF);
      // Reset in mid-run restores control, gain 1, divider, count, mask, flags and line view
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wr(8'h30, 32'h5A);
      rd(8'h30, 32'h0);
      rd(`AEA_OFS_CTRL, 32'h0);
      rd(`AEA_OFS_GAIN1, 32'h0);
      rd(`AEA_OFS_DIV, 32'h0);
      rd(`AEA_OFS_COUNT, 32'h0);
      rd(`AEA_OFS_MASK, 32'hF);
      rd(`AEA_OFS_FLAGS, 32'h0);
      rd(`AEA_OFS_LINE_VIEW, 32'h0);
      tally_and_finish();
   end
endmodule
